/* src/rca_core.sv */
// Execution datapath of the 8-bit core: fetch, two-stage pipeline, ALU and file registers.
// Notes on behaviour
// - Instructions are 12-bit words, one word each, fetched in one cycle.
// - Fetch of next instruction overlaps execution; branches cost one extra cycle.
// - Program bus and data file paths are separate and work concurrently.
// - Program counter wraps within a 512, 1K or 2K word internal store.
// - Special registers, program counter low byte included, sit in file space.
// - ALU is 8 bits: add, subtract, shift, Boolean; two's complement.
// - Two-operand ops use accumulator with file or literal; one-operand ops read a file and write it or the accumulator.
// - Accumulator is an 8-bit working register with no file address.
// - ALU updates carry, nibble carry and zero flags by instruction.
// - In subtraction carry and nibble carry act as inverted borrow outputs, clear on a borrow.
// - Master clear low resets the core.
// - In RC mode the clock pin outputs one quarter of the oscillator.
// - Two select bits choose one of four oscillator modes.
// - Crystal modes also accept an external clock on the crystal input.
// - Timer-zero external clock pin counts timer-zero when selected.
// - Two bidirectional ports: 4-bit port A and 8-bit port B.
`timescale 1ns/1ps
`include "rca_consts.svh"
module rca_core import rca_pkg::*; (
    // Clock, enable and resets.
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic reset,
    input wire logic master_clear_n,
    // Oscillator configuration and cycle clock pin.
    input wire logic [1:0] oscillator_select_bits,
    output logic crystal_out_or_cycle_clock,
    output logic crystal_out_or_cycle_clock_oe,
    // Variant and timer configuration.
    input wire logic [1:0] prog_size_sel,
    input wire logic timer_src_ext,
    input wire logic timer_ext_clk_in,
    // Program store loading.
    input wire logic prog_load_en,
    input wire logic [10:0] prog_load_addr,
    input wire logic [11:0] prog_load_data,
    // Port A pins.
    input wire logic [3:0] port_a_pin_in,
    output logic [3:0] port_a_pin_out,
    output logic [3:0] port_a_pin_oe,
    // Port B pins.
    input wire logic [7:0] port_b_pin_in,
    output logic [7:0] port_b_pin_out,
    output logic [7:0] port_b_pin_oe,
    // Observation.
    output logic [10:0] pc_out,
    output logic [7:0] acc_out,
    output logic [2:0] status_out,
    output logic cycle_end
);
    rca_state_s q;
    rca_state_s d;
    rca_prog_if prog ();
    rca_osc_mode_e osc_mode;
    rca_alu_op_e alu_op;
    logic rst_any;
    logic [10:0] pc_mask;
    logic is_goto;
    logic is_lit;
    logic is_file;
    logic exec_now;
    logic [4:0] faddr;
    logic [7:0] fval;
    logic [7:0] alu_b;
    logic [7:0] alu_res;
    logic alu_c;
    logic alu_dc;
    logic alu_z;
    logic upd_c;
    logic upd_dc;
    logic upd_z;
    logic alu_ok;
    logic to_file;
    logic ext_edge;

    // Either reset source restarts the core; both act on the clock edge.
    assign rst_any = reset | ~master_clear_n;
    assign osc_mode = rca_osc_mode_e'(oscillator_select_bits);

    // Size select codes 2 and 3 both give the full store of 2K words.
    // A smaller variant simply ignores the upper address bits.
    // Store depth of the chosen variant bounds every program address.
    always_comb begin
        case (prog_size_sel)
            2'h0: pc_mask = `RCA_MASK_512;
            2'h1: pc_mask = `RCA_MASK_1K;
            default: pc_mask = `RCA_MASK_2K;
        endcase
    end

    // Instruction word layout used by this core:
    //   bit 11 set: jump, bits 10:0 are the target.
    //   bits 11:10 at 01: literal form, bits 9:8 pick move, and, or, xor,
    //   and bits 7:0 hold the constant that meets the accumulator.
    //   bits 11:10 at 00: file form, bits 9:6 pick the operation,
    //   bit 5 sends the result to the file, bits 4:0 name the file.
    // File codes run add, subtract, and, or, xor, move, increment,
    // decrement, complement, clear, rotate left, rotate right, swap.
    // Codes 13 to 15 are reserved and do nothing, so a stray word
    // cannot disturb the flags.
    // Instruction classes; every instruction is exactly one 12-bit word.
    assign is_goto = q.ir[`RCA_OP_GOTO_BIT];
    assign is_lit = q.ir[11:10] == `RCA_CLASS_LIT;
    assign is_file = q.ir[11:10] == `RCA_CLASS_FILE;
    assign exec_now = (q.phase == `RCA_PHASE_LAST) && q.ir_valid;
    assign faddr = (q.ir[4:0] == `RCA_ADDR_INDIRECT) ? q.fsr : q.ir[4:0];
    assign to_file = is_file && q.ir[`RCA_DEST_BIT];

    // File map: 00 indirect through the select register, 01 timer,
    // 02 counter low byte, 03 status, 04 select register, 05 and 06 pins,
    // 07 and 08 directions, 10h to 17h general registers.
    // Addresses 18h to 1Fh alias the general registers, as only eight exist.
    // Addresses 09h to 0Fh read as zero and ignore writes.
    // Port reads return pin levels, not latches.
    // File read; the accumulator has no address and never appears here.
    always_comb begin
        fval = 8'h00;
        if (faddr >= `RCA_ADDR_GPR_BASE) begin
            fval = q.gpr[faddr[2:0] & `RCA_GPR_SEL];
        end else begin
            case (faddr)
                `RCA_ADDR_TIMER: fval = q.timer;
                `RCA_ADDR_PCL: fval = q.pc[7:0];
                `RCA_ADDR_STATUS: fval = {5'h00, q.status};
                `RCA_ADDR_FSR: fval = {3'h0, q.fsr};
                `RCA_ADDR_PORTA: fval = {4'h0, port_a_pin_in};
                `RCA_ADDR_PORTB: fval = port_b_pin_in;
                `RCA_ADDR_DIRA: fval = {4'h0, q.dir_a};
                `RCA_ADDR_DIRB: fval = q.dir_b;
                default: fval = 8'h00;
            endcase
        end
    end

    // Operation select: literal forms reuse the Boolean and pass operations.
    always_comb begin
        alu_op = RCA_ALU_NONE;
        alu_b = fval;
        if (is_lit) begin
            alu_b = q.ir[7:0];
            case (q.ir[9:8])
                2'h0: alu_op = RCA_ALU_PASS;
                2'h1: alu_op = RCA_ALU_AND;
                2'h2: alu_op = RCA_ALU_IOR;
                default: alu_op = RCA_ALU_XOR;
            endcase
        end else if (is_file) begin
            alu_op = rca_alu_op_e'(q.ir[9:6]);
        end
    end

    rca_alu u_alu (
        .acc(q.w),
        .opnd(alu_b),
        .carry_in(q.status[`RCA_ST_C]),
        .op(alu_op),
        .result(alu_res),
        .carry_out(alu_c),
        .nibble_out(alu_dc),
        .zero_out(alu_z),
        .upd_carry(upd_c),
        .upd_nibble(upd_dc),
        .upd_zero(upd_z),
        .res_valid(alu_ok)
    );

    rca_prog_mem u_prog (
        .ref_clk(ref_clk),
        .clk_en(clk_en),
        .bus(prog.mem),
        .load_en(prog_load_en),
        .load_addr(prog_load_addr),
        .load_data(prog_load_data)
    );

    // Fetch is issued in the first phase so read data is settled by the last.
    assign prog.rd_en = q.phase == `RCA_PHASE_FETCH;
    assign prog.rd_addr = q.pc;

    // The timer pin is not synchronised here; a board that drives it
    // from another clock must add two flip-flops in front of the core.
    // One count needs the pin low for one edge and then high for one.
    // Timer pin is taken as synchronous; only its rising edge counts.
    assign ext_edge = timer_ext_clk_in & ~q.ext_prev;

    // One instruction cycle is four enabled edges:
    //   phase 0 issues the fetch at the program counter;
    //   phases 1 and 2 let the registered read data settle;
    //   the edge leaving phase 3 loads the new word, steps the counter
    //   and carries out the word already in the pipe.
    // A jump or a write of the counter low byte drops the prefetched
    // word, so those take two cycles; all others take one.
    // Masking every address to the store depth makes a run off the end
    // of a small store wrap to address zero.
    // Next-state logic: phase divider, fetch, execute and write-back.
    always_comb begin
        d = q;
        d.phase = q.phase + 2'h1;
        d.ext_prev = timer_ext_clk_in;
        if (timer_src_ext ? ext_edge : (q.phase == `RCA_PHASE_LAST)) begin
            d.timer = q.timer + 8'h01;
        end
        if (q.phase == `RCA_PHASE_LAST) begin
            // Next word enters the pipe while the current one executes.
            d.ir = prog.rd_data;
            d.ir_valid = 1'b1;
            d.pc = (q.pc + 11'h001) & pc_mask;
        end
        if (exec_now && is_goto) begin
            // The word already fetched is dropped, costing one cycle.
            d.pc = q.ir[10:0] & pc_mask;
            d.ir_valid = 1'b0;
        end else if (exec_now && alu_ok) begin
            if (upd_c) begin
                d.status[`RCA_ST_C] = alu_c;
            end
            if (upd_dc) begin
                d.status[`RCA_ST_DC] = alu_dc;
            end
            if (upd_z) begin
                d.status[`RCA_ST_Z] = alu_z;
            end
            if (!to_file) begin
                d.w = alu_res;
            end else if (faddr >= `RCA_ADDR_GPR_BASE) begin
                d.gpr[faddr[2:0] & `RCA_GPR_SEL] = alu_res;
            end else begin
                case (faddr)
                    `RCA_ADDR_TIMER: d.timer = alu_res;
                    `RCA_ADDR_PCL: begin
                        d.pc = {q.pc[10:8], alu_res} & pc_mask;
                        d.ir_valid = 1'b0;
                    end
                    // Flags set by the operation itself win over the written bits.
                    `RCA_ADDR_STATUS: begin
                        d.status = alu_res[2:0];
                        if (upd_c) begin
                            d.status[`RCA_ST_C] = alu_c;
                        end
                        if (upd_dc) begin
                            d.status[`RCA_ST_DC] = alu_dc;
                        end
                        if (upd_z) begin
                            d.status[`RCA_ST_Z] = alu_z;
                        end
                    end
                    `RCA_ADDR_FSR: d.fsr = alu_res[4:0];
                    `RCA_ADDR_PORTA: d.port_a_lat = alu_res[3:0];
                    `RCA_ADDR_PORTB: d.port_b_lat = alu_res;
                    `RCA_ADDR_DIRA: d.dir_a = alu_res[3:0];
                    `RCA_ADDR_DIRB: d.dir_b = alu_res;
                    default: d.w = q.w;
                endcase
            end
        end
        if (rst_any) begin
            d = '0;
            d.pc = `RCA_PC_RESET;
            d.dir_a = `RCA_DIRA_RESET;
            d.dir_b = `RCA_DIRB_RESET;
        end
    end

    // Both resets act on the clock edge only; a glitch between edges is lost.
    // Reset drops every port output enable at once, so no port pin is driven until
    // the program sets its direction register again.
    // A writer of the counter low byte keeps the page bits of the counter.
    // Reset is honoured even while the clock enable is low.
    always_ff @(posedge ref_clk) begin
        if (clk_en || rst_any) begin
            q <= d;
        end
    end

    // Cycle clock: low in phases 0 and 1, high in 2 and 3, one quarter of ref_clk.
    assign crystal_out_or_cycle_clock = q.phase[1];
    // In crystal modes the pin belongs to the resonator or an external clock source.
    assign crystal_out_or_cycle_clock_oe = osc_mode == RCA_OSC_RES_CAP;

    // Direction bit high means input, so the pin is driven when it is low.
    assign port_a_pin_out = q.port_a_lat;
    assign port_a_pin_oe = ~q.dir_a;
    assign port_b_pin_out = q.port_b_lat;
    assign port_b_pin_oe = ~q.dir_b;

    // These outputs serve test and debug; they show the state as it
    // stands after the last execute edge.
    // Between execute edges only the phase, timer and fetch state move.
    // Observation outputs straight from state.
    assign pc_out = q.pc;
    assign acc_out = q.w;
    assign status_out = q.status;
    assign cycle_end = clk_en && (q.phase == `RCA_PHASE_LAST);
endmodule

/* src/rca_consts.svh */
// Offsets, field positions, reset values and timing counts of the core datapath.
`ifndef RCA_CONSTS_SVH
`define RCA_CONSTS_SVH
// Oscillator periods per instruction cycle.
`define RCA_OSC_PER_CYCLE 3'h4
`define RCA_PHASE_FETCH 2'h0
`define RCA_PHASE_LAST 2'h3
// Widths.
`define RCA_IW 12
`define RCA_PCW 11
`define RCA_DW 8
// File register addresses.
`define RCA_ADDR_INDIRECT 5'h00
`define RCA_ADDR_TIMER 5'h01
`define RCA_ADDR_PCL 5'h02
`define RCA_ADDR_STATUS 5'h03
`define RCA_ADDR_FSR 5'h04
`define RCA_ADDR_PORTA 5'h05
`define RCA_ADDR_PORTB 5'h06
`define RCA_ADDR_DIRA 5'h07
`define RCA_ADDR_DIRB 5'h08
`define RCA_ADDR_GPR_BASE 5'h10
`define RCA_GPR_SEL 3'h7
// Status bit positions.
`define RCA_ST_C 0
`define RCA_ST_DC 1
`define RCA_ST_Z 2
// Instruction fields.
`define RCA_OP_GOTO_BIT 11
`define RCA_CLASS_LIT 2'h1
`define RCA_CLASS_FILE 2'h0
`define RCA_DEST_BIT 5
// Program store depth masks per variant.
`define RCA_MASK_512 11'h1FF
`define RCA_MASK_1K 11'h3FF
`define RCA_MASK_2K 11'h7FF
`define RCA_PROG_DEPTH 2048
// Reset values.
`define RCA_PC_RESET 11'h000
`define RCA_DIRA_RESET 4'hF
`define RCA_DIRB_RESET 8'hFF
`endif

/* src/rca_pkg.sv */
// Types shared by the core datapath modules.
package rca_pkg;
    typedef enum logic [1:0] {
        RCA_OSC_SLOW_CRYSTAL,
        RCA_OSC_CRYSTAL,
        RCA_OSC_FAST_CRYSTAL,
        RCA_OSC_RES_CAP
    } rca_osc_mode_e;

    typedef enum logic [3:0] {
        RCA_ALU_ADD, RCA_ALU_SUB, RCA_ALU_AND, RCA_ALU_IOR,
        RCA_ALU_XOR, RCA_ALU_PASS, RCA_ALU_INC, RCA_ALU_DEC,
        RCA_ALU_COM, RCA_ALU_CLR, RCA_ALU_RLC, RCA_ALU_RRC,
        RCA_ALU_SWAP, RCA_ALU_NONE
    } rca_alu_op_e;

    typedef struct packed {
        logic [1:0] phase;
        logic [10:0] pc;
        logic [11:0] ir;
        logic ir_valid;
        logic [7:0] w;
        logic [2:0] status;
        logic [4:0] fsr;
        logic [7:0] timer;
        logic [3:0] port_a_lat;
        logic [7:0] port_b_lat;
        logic [3:0] dir_a;
        logic [7:0] dir_b;
        logic [7:0][7:0] gpr;
        logic ext_prev;
    } rca_state_s;

    typedef struct packed {
        logic [11:0] rd_data;
    } rca_mem_state_s;
endpackage

/* src/rca_prog_if.sv */
// Program-memory bus between the core and its program store.
`timescale 1ns/1ps
interface rca_prog_if;
    logic rd_en;
    logic [10:0] rd_addr;
    logic [11:0] rd_data;
    modport core (output rd_en, output rd_addr, input rd_data);
    modport mem (input rd_en, input rd_addr, output rd_data);
endinterface

/* src/rca_prog_mem.sv */
// Internal program store, 2K words of 12 bits, with registered read data.
`timescale 1ns/1ps
`include "rca_consts.svh"
module rca_prog_mem import rca_pkg::*; (
    // Clock and enable.
    input wire logic ref_clk,
    input wire logic clk_en,
    // Fetch side.
    rca_prog_if.mem bus,
    // Loading port.
    input wire logic load_en,
    input wire logic [10:0] load_addr,
    input wire logic [11:0] load_data
);
    logic [11:0] store [`RCA_PROG_DEPTH];
    rca_mem_state_s q;
    rca_mem_state_s d;

    // Read data only moves on a fetch, so it holds steady for the rest of the cycle.
    always_comb begin
        d = q;
        if (bus.rd_en) begin
            d.rd_data = store[bus.rd_addr];
        end
    end

    // The store itself has no reset; its contents are whatever was loaded.
    always_ff @(posedge ref_clk) begin
        if (clk_en) begin
            q <= d;
            if (load_en) begin
                store[load_addr] <= load_data;
            end
        end
    end

    assign bus.rd_data = q.rd_data;
endmodule

/* src/rca_alu.sv */
// Eight-bit arithmetic and logic unit with carry, nibble-carry and zero outputs.
`timescale 1ns/1ps
`include "rca_consts.svh"
module rca_alu import rca_pkg::*; (
    // Operands.
    input wire logic [7:0] acc,
    input wire logic [7:0] opnd,
    input wire logic carry_in,
    input rca_alu_op_e op,
    // Results.
    output logic [7:0] result,
    output logic carry_out,
    output logic nibble_out,
    output logic zero_out,
    output logic upd_carry,
    output logic upd_nibble,
    output logic upd_zero,
    output logic res_valid
);
    logic [8:0] sum;
    logic [4:0] nib;

    // Subtraction is operand minus accumulator done as an add of the inverse.
    always_comb begin
        sum = 9'h000;
        nib = 5'h00;
        result = 8'h00;
        carry_out = 1'b0;
        upd_carry = 1'b0;
        upd_nibble = 1'b0;
        upd_zero = 1'b1;
        res_valid = 1'b1;
        case (op)
            RCA_ALU_ADD, RCA_ALU_SUB: begin
                if (op == RCA_ALU_ADD) begin
                    sum = {1'b0, opnd} + {1'b0, acc};
                    nib = {1'b0, opnd[3:0]} + {1'b0, acc[3:0]};
                end else begin
                    sum = {1'b0, opnd} + {1'b0, ~acc} + 9'h001;
                    nib = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
                end
                result = sum[7:0];
                carry_out = sum[8];
                upd_carry = 1'b1;
                upd_nibble = 1'b1;
            end
            RCA_ALU_AND: result = acc & opnd;
            RCA_ALU_IOR: result = acc | opnd;
            RCA_ALU_XOR: result = acc ^ opnd;
            RCA_ALU_PASS: result = opnd;
            RCA_ALU_INC: result = opnd + 8'h01;
            RCA_ALU_DEC: result = opnd - 8'h01;
            RCA_ALU_COM: result = ~opnd;
            RCA_ALU_CLR: result = 8'h00;
            RCA_ALU_RLC: begin
                result = {opnd[6:0], carry_in};
                carry_out = opnd[7];
                upd_carry = 1'b1;
                upd_zero = 1'b0;
            end
            RCA_ALU_RRC: begin
                result = {carry_in, opnd[7:1]};
                carry_out = opnd[0];
                upd_carry = 1'b1;
                upd_zero = 1'b0;
            end
            RCA_ALU_SWAP: begin
                result = {opnd[3:0], opnd[7:4]};
                upd_zero = 1'b0;
            end
            default: begin
                upd_zero = 1'b0;
                res_valid = 1'b0;
            end
        endcase
    end

    // Flag outputs; the caller applies only those whose update line is high.
    assign nibble_out = nib[4];
    assign zero_out = (result == 8'h00);
endmodule

/* testbench/rca_pin_model.sv */
// Board-side model of the two bidirectional ports of the core.
`timescale 1ns/1ps
module rca_pin_model (
    // Core side of the pins.
    input wire logic [3:0] port_a_pin_out,
    input wire logic [3:0] port_a_pin_oe,
    input wire logic [7:0] port_b_pin_out,
    input wire logic [7:0] port_b_pin_oe,
    // Outside sources seen where the core does not drive.
    input wire logic [3:0] ext_a,
    input wire logic [7:0] ext_b,
    // Resolved pin levels.
    output logic [3:0] port_a_pin_in,
    output logic [7:0] port_b_pin_in
);
    // A driven pin shows the core latch, so a stale outside level never hides a latch fault.
    assign port_a_pin_in = (port_a_pin_oe & port_a_pin_out) | (~port_a_pin_oe & ext_a);
    assign port_b_pin_in = (port_b_pin_oe & port_b_pin_out) | (~port_b_pin_oe & ext_b);
endmodule

/* testbench/rca_core_asserts.sv */
// Port-level checker for the core datapath, bound into the top module.
`timescale 1ns/1ps
module rca_core_asserts (
    // Clock and resets.
    input wire logic ref_clk,
    input wire logic clk_en,
    input wire logic reset,
    input wire logic master_clear_n,
    // Oscillator and program store configuration.
    input wire logic [1:0] oscillator_select_bits,
    input wire logic crystal_out_or_cycle_clock,
    input wire logic crystal_out_or_cycle_clock_oe,
    input wire logic [1:0] prog_size_sel,
    // Observed state.
    input wire logic [3:0] port_a_pin_oe,
    input wire logic [7:0] port_b_pin_out,
    input wire logic [7:0] port_b_pin_oe,
    input wire logic [10:0] pc_out,
    input wire logic [7:0] acc_out,
    input wire logic [2:0] status_out,
    input wire logic cycle_end
);
    logic run_en;
    logic [10:0] pc_mask;

    // An edge only advances the cycle when enabled and out of reset.
    assign run_en = clk_en && !reset && master_clear_n;
    assign pc_mask = (prog_size_sel == 2'h0) ? 11'h1FF :
        (prog_size_sel == 2'h1) ? 11'h3FF : 11'h7FF;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset || !master_clear_n);

    // Steps of one instruction cycle.
    sequence exec_then_run;
        cycle_end ##1 run_en [*4];
    endsequence
    sequence clk_rise_run;
        $rose(crystal_out_or_cycle_clock) && clk_en ##1 clk_en;
    endsequence

    chk_reset_state: assert property (disable iff (1'b0) (reset || !master_clear_n) |=>
        pc_out == 11'h000 && acc_out == 8'h00 && status_out == 3'h0 && port_b_pin_oe == 8'h00
        && port_a_pin_oe == 4'h0 && port_b_pin_out == 8'h00 && !crystal_out_or_cycle_clock)
        else $error("state not cleared by reset");
    chk_cycle_gap: assert property (cycle_end |=> !cycle_end [*3])
        else $error("execute pulses closer than four cycles");
    chk_cycle_period: assert property (exec_then_run |-> cycle_end)
        else $error("execute pulse missing after four enabled cycles");
    chk_clkout_phase: assert property (cycle_end |-> crystal_out_or_cycle_clock ##1
        !crystal_out_or_cycle_clock)
        else $error("cycle clock out of phase");
    chk_clkout_rise: assert property (clk_rise_run |-> cycle_end)
        else $error("cycle clock rise not one cycle before execute");
    chk_clkout_oe: assert property (crystal_out_or_cycle_clock_oe ==
        (oscillator_select_bits == 2'h3))
        else $error("cycle clock pin drive wrong for mode");
    chk_pc_wrap: assert property (pc_out <= pc_mask)
        else $error("program counter beyond store depth");
    chk_quiet_state: assert property (!cycle_end && !reset && master_clear_n |=>
        $stable(pc_out) && $stable(acc_out) && $stable(status_out)
        && $stable(port_b_pin_out) && $stable(port_b_pin_oe))
        else $error("state changed outside execute edge");
endmodule

bind rca_core rca_core_asserts u_chk (.*);

/* testbench/testbench.sv */
// Self-checking bench for the core datapath: operation table, branch, ports and resets.
`timescale 1ns/1ps
module testbench;
    typedef struct packed {
        logic [11:0] op;
        logic [7:0] a;
        logic [7:0] b;
        logic [7:0] w;
        logic [2:0] s;
    } rca_row_s;

    // Design and board signals.
    logic ref_clk, clk_en, reset, master_clear_n, timer_src_ext, timer_ext_clk_in;
    logic prog_load_en, crystal_out_or_cycle_clock, crystal_out_or_cycle_clock_oe, cycle_end;
    logic [1:0] oscillator_select_bits, prog_size_sel;
    logic [10:0] prog_load_addr, pc_out;
    logic [11:0] prog_load_data;
    logic [3:0] port_a_pin_in, port_a_pin_out, port_a_pin_oe, ext_a;
    logic [7:0] port_b_pin_in, port_b_pin_out, port_b_pin_oe, ext_b, acc_out;
    logic [2:0] status_out;
    int n_fail, comparisons, cycles;

    // Operation under test, W literal, file value, expected W and {Z,DC,C}.
    rca_row_s rows [19] = '{
        '{12'h010, 8'h0F, 8'h01, 8'h10, 3'h2}, '{12'h010, 8'h80, 8'h80, 8'h00, 3'h5},
        '{12'h050, 8'h06, 8'h05, 8'hFF, 3'h0}, '{12'h050, 8'h33, 8'h33, 8'h00, 3'h7},
        '{12'h090, 8'hF0, 8'h3C, 8'h30, 3'h0}, '{12'h0D0, 8'h0F, 8'h30, 8'h3F, 3'h0},
        '{12'h110, 8'h5A, 8'h5A, 8'h00, 3'h4}, '{12'h150, 8'h11, 8'h00, 8'h00, 3'h4},
        '{12'h190, 8'h01, 8'hFF, 8'h00, 3'h4}, '{12'h1D0, 8'h01, 8'h01, 8'h00, 3'h4},
        '{12'h210, 8'h01, 8'hFF, 8'h00, 3'h4}, '{12'h250, 8'h77, 8'h77, 8'h00, 3'h4},
        '{12'h290, 8'h01, 8'h81, 8'h02, 3'h1}, '{12'h2D0, 8'h01, 8'h81, 8'h40, 3'h1},
        '{12'h310, 8'h01, 8'hA5, 8'h5A, 3'h0}, '{12'h5F0, 8'h3C, 8'h01, 8'h30, 3'h0},
        '{12'h603, 8'h3C, 8'h01, 8'h3F, 3'h0}, '{12'h73C, 8'h3C, 8'h01, 8'h00, 3'h4},
        '{12'h350, 8'h42, 8'h10, 8'h42, 3'h0}};

    rca_core u_dut (.*);
    rca_pin_model u_pins (.*);

    // Oscillator clock at 50 MHz.
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Hang guard; the whole run needs about 1550 cycles.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 10000) begin
            n_fail++;
            end_sim();
        end
    end

    task automatic end_sim();
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t value %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chk_flags(input logic [2:0] got, input logic [2:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH %0t flags %b expected %b", $time, got, exp);
        end
    endtask

    task automatic load_word(input logic [10:0] a, input logic [11:0] d);
        prog_load_en <= 1'b1;
        prog_load_addr <= a;
        prog_load_data <= d;
        @(posedge ref_clk);
    endtask

    // Loads six words under reset, releases it and lets the program settle.
    task automatic boot(input logic [11:0] p [6]);
        reset <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            load_word(11'(i), p[i]);
        end
        prog_load_en <= 1'b0;
        reset <= 1'b0;
        repeat (60) @(posedge ref_clk);
    endtask

    // Main sequence; each program ends in a jump that closes a loop so results stay put.
    initial begin
        {clk_en, reset, master_clear_n} = 3'h7;
        {timer_src_ext, timer_ext_clk_in, prog_load_en} = 3'h0;
        oscillator_select_bits = 2'h3;
        prog_size_sel = 2'h2;
        prog_load_addr = 11'h000;
        prog_load_data = 12'h000;
        ext_a = 4'h9;
        ext_b = 8'h3C;
        n_fail = 0;
        comparisons = 0;
        cycles = 0;
        repeat (8) @(posedge ref_clk);
        // File value is built by clear then add, since no plain store of W exists.
        foreach (rows[i]) begin
            boot('{{4'h4, rows[i].b}, 12'h270, 12'h030, {4'h4, rows[i].a}, rows[i].op, 12'h805});
            chk_val({3'h0, acc_out}, {3'h0, rows[i].w});
            chk_flags(status_out, rows[i].s);
        end
        // Jump to the last word of the smallest store; a missed wrap runs into 200h.
        prog_size_sel <= 2'h0;
        reset <= 1'b1;
        load_word(11'h1FF, 12'h421);
        load_word(11'h200, 12'h499);
        boot('{12'h9FF, 12'h805, 12'h805, 12'h805, 12'h805, 12'h805});
        clk_en <= 1'b0;
        repeat (20) @(posedge ref_clk);
        clk_en <= 1'b1;
        repeat (20) @(posedge ref_clk);
        chk_val({3'h0, acc_out}, 11'h021);
        // Port B as outputs with a latch value; port A read back from the board.
        prog_size_sel <= 2'h2;
        boot('{12'h268, 12'h266, 12'h4A5, 12'h026, 12'h145, 12'h805});
        chk_val({3'h0, port_b_pin_out}, 11'h0A5);
        chk_val({3'h0, port_b_pin_oe}, 11'h0FF);
        chk_val({7'h0, port_a_pin_oe}, 11'h000);
        chk_val({7'h0, acc_out[3:0]}, 11'h009);
        // Timer counts five rising edges of its pin; port A driven with 6.
        timer_src_ext <= 1'b1;
        boot('{12'h267, 12'h406, 12'h025, 12'h141, 12'h803, 12'h805});
        repeat (5) begin
            timer_ext_clk_in <= 1'b1;
            repeat (2) @(posedge ref_clk);
            timer_ext_clk_in <= 1'b0;
            repeat (2) @(posedge ref_clk);
        end
        repeat (16) @(posedge ref_clk);
        chk_val({3'h0, acc_out}, 11'h005);
        chk_val({7'h0, port_a_pin_out}, 11'h006);
        chk_val({7'h0, port_a_pin_oe}, 11'h00F);
        // Master clear in mid-run clears W and the program counter; the port B enables, already off in this program, stay off.
        master_clear_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        master_clear_n <= 1'b1;
        @(posedge ref_clk);
        chk_val({3'h0, port_b_pin_oe}, 11'h000);
        chk_val({3'h0, acc_out}, 11'h000);
        chk_val(pc_out, 11'h000);
        // Only the resistor-capacitor mode drives the cycle clock pin.
        for (int m = 0; m < 4; m++) begin
            oscillator_select_bits <= 2'(m);
            repeat (2) @(posedge ref_clk);
            chk_val({10'h0, crystal_out_or_cycle_clock_oe}, {10'h0, m == 3});
        end
        end_sim();
    end
endmodule
